// ===== core/acs_cfg.svh
// Purpose: constants for the acquisition/conversion sequencer
// Assumes: register port with one-cycle read latency, 8-bit data
// Notes: offsets are word indices on the plain register port
// Overview of operation
// - acquisition time is applied on every start, not only the first
// - acquisition select 000: start stops sampling and converts at once
// - nonzero select: keep sampling for programmed time, then convert automatically
// - conversion end clears start bit, sets done flag, resumes sampling
// - no status shows acquisition finished or conversion started
// - each 10-bit conversion takes exactly 11 bit periods
// - clock select decodes 2,4,8,16,32,64 oscillator periods or x11 internal RC
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH
`define ACS_ADDR_W 3
`define ACS_OFF_CTRL 3'h0
`define ACS_OFF_TIMING 3'h1
`define ACS_OFF_STATUS 3'h2
`define ACS_OFF_CLEAR 3'h3
`define ACS_OFF_ENABLE 3'h4
`define ACS_CTRL_GO_BIT 0
`define ACS_ADCS_LSB 0
`define ACS_ACQT_LSB 3
`define ACS_TIMING_RST 6'h00
`define ACS_CONV_BITS 4'hB
`define ACS_RC_DIV 8'h10
`endif

// ===== core/acs_pkg.sv
// Purpose: types for the acquisition/conversion sequencer
// Assumes: nothing
// Notes: gray-coded states along idle -> acquire -> convert
package acs_pkg;
  typedef enum logic [1:0] {
    ACS_IDLE = 2'b00,
    ACS_ACQ = 2'b01,
    ACS_CONV = 2'b11
  } acs_state_t;
endpackage

// ===== core/acs_tick_gen.sv
// Purpose: bit-period tick generator
// Assumes: rc_tick is already synchronised
// Notes: counts only while run is high so every sequence starts on a clean period, except x11 on the free-running RC
`timescale 1ns/1ps
`include "acs_cfg.svh"
module acs_tick_gen (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [2:0] clk_sel,
  input wire logic rc_tick,
  output logic tick
);
  logic [5:0] div_r;
  logic [5:0] limit;
  always_comb begin
    // bits 1:0 give the power, bit 2 doubles it
    case (clk_sel[1:0])
      2'b00: limit = clk_sel[2] ? 6'h03 : 6'h01;
      2'b01: limit = clk_sel[2] ? 6'h0F : 6'h07;
      2'b10: limit = clk_sel[2] ? 6'h3F : 6'h1F;
      default: limit = 6'h00;
    endcase
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 6'h00;
    end else if (!run || div_r == limit) begin
      div_r <= 6'h00;
    end else begin
      div_r <= div_r + 6'h01;
    end
  end
  // x11 follows the internal RC oscillator instead of the divider
  assign tick = (clk_sel[1:0] == 2'b11) ? (run & rc_tick) : (run & (div_r == limit));
endmodule

// ===== core/acs_seq.sv
// Purpose: acquisition and conversion sequencer for a 10-bit converter
// Assumes: register strobes come from logic on sys_clk; rc_clk_in is asynchronous
// Notes: the analog sampler and converter sit outside; this block only times them
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "acs_cfg.svh"
module acs_seq (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [`ACS_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic rc_clk_in,
  output logic sample_en,
  output logic conv_active,
  output logic bit_strobe,
  output logic irq,
  output acs_pkg::acs_state_t seq_state
);
  import acs_pkg::*;

  acs_state_t state_r;
  logic go_r;
  logic [5:0] timing_r;
  logic done_flag_r;
  logic done_en_r;
  logic [2:0] acq_cnt_r;
  logic [3:0] bit_cnt_r;
  logic rc_s1_r;
  logic rc_s2_r;
  logic rc_s3_r;
  logic rc_tick;
  logic tick;
  logic wr_go;
  logic conv_end;
  logic [2:0] acqt;

  assign acqt = timing_r[`ACS_ACQT_LSB +: 3];
  assign wr_go = reg_wr && reg_addr == `ACS_OFF_CTRL && reg_wdata[`ACS_CTRL_GO_BIT];
  assign conv_end = state_r == ACS_CONV && tick && bit_cnt_r == 4'h1;

  // rc oscillator pin: two flops, then edge detect on the settled copy
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rc_s1_r <= 1'b0;
      rc_s2_r <= 1'b0;
      rc_s3_r <= 1'b0;
    end else begin
      rc_s1_r <= rc_clk_in;
      rc_s2_r <= rc_s1_r;
      rc_s3_r <= rc_s2_r;
    end
  end
  assign rc_tick = rc_s2_r & ~rc_s3_r;

  acs_tick_gen u_tick (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .run(state_r != ACS_IDLE),
    .clk_sel(timing_r[`ACS_ADCS_LSB +: 3]),
    .rc_tick(rc_tick),
    .tick(tick)
  );

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      timing_r <= `ACS_TIMING_RST;
    end else if (reg_wr && reg_addr == `ACS_OFF_TIMING) begin
      timing_r <= reg_wdata[5:0];
    end
  end

  // sequencer; start writes while busy fall through untouched
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ACS_IDLE;
      go_r <= 1'b0;
      acq_cnt_r <= 3'h0;
      bit_cnt_r <= 4'h0;
    end else begin
      case (state_r)
        ACS_IDLE: begin
          if (wr_go) begin
            go_r <= 1'b1;
            acq_cnt_r <= acqt;
            bit_cnt_r <= `ACS_CONV_BITS;
            // select 000 converts at once; else keep sampling first
            state_r <= (acqt == 3'h0) ? ACS_CONV : ACS_ACQ;
          end
        end
        ACS_ACQ: begin
          if (tick) begin
            acq_cnt_r <= acq_cnt_r - 3'h1;
            if (acq_cnt_r == 3'h1) begin
              state_r <= ACS_CONV;
            end
          end
        end
        ACS_CONV: begin
          if (tick) begin
            bit_cnt_r <= bit_cnt_r - 4'h1;
            if (conv_end) begin
              go_r <= 1'b0;
              state_r <= ACS_IDLE;
            end
          end
        end
        default: state_r <= ACS_IDLE;
      endcase
    end
  end

  // done flag: set wins over a same-cycle clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_flag_r <= 1'b0;
    end else if (conv_end) begin
      done_flag_r <= 1'b1;
    end else if (reg_wr && reg_addr == `ACS_OFF_CLEAR && reg_wdata[0]) begin
      done_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_en_r <= 1'b0;
    end else if (reg_wr && reg_addr == `ACS_OFF_ENABLE) begin
      done_en_r <= reg_wdata[0];
    end
  end

  // of the sequencer status only go and done are visible; acquire versus convert is not
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `ACS_OFF_CTRL: reg_rdata <= {7'h00, go_r};
        `ACS_OFF_TIMING: reg_rdata <= {2'b00, timing_r};
        `ACS_OFF_STATUS: reg_rdata <= {7'h00, done_flag_r};
        `ACS_OFF_ENABLE: reg_rdata <= {7'h00, done_en_r};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // registered outputs trail the state by one cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_en <= 1'b1;
      conv_active <= 1'b0;
      bit_strobe <= 1'b0;
      irq <= 1'b0;
      seq_state <= ACS_IDLE;
    end else begin
      sample_en <= state_r != ACS_CONV;
      conv_active <= state_r == ACS_CONV;
      bit_strobe <= state_r == ACS_CONV && tick;
      irq <= done_flag_r & done_en_r;
      seq_state <= state_r;
    end
  end
endmodule

// ===== dv/acs_seq_properties.sv
// Purpose: timing checks on the sequencer ports
// Assumes: one clock domain
// Notes: done and enable bits sit inside, so irq is judged by the bench
`timescale 1ns/1ps
`include "acs_cfg.svh"
module acs_seq_chk (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [`ACS_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic sample_en,
  input wire logic conv_active,
  input wire logic bit_strobe,
  input wire acs_pkg::acs_state_t seq_state
);
  import acs_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_start;
    seq_state == ACS_IDLE && reg_wr && reg_addr == 3'h0 && reg_wdata[0];
  endsequence
  sequence s_busy_rd;
    // seq_state trails by a cycle; the final strobe marks the cycle go has already dropped
    reg_rd && reg_addr == 3'h0 && seq_state != ACS_IDLE && !bit_strobe;
  endsequence
  // the registered state copy needs two edges to show the start
  property p_start; s_start |-> ##2 seq_state != ACS_IDLE; endproperty
  property p_acq_samp; seq_state == ACS_ACQ |-> sample_en; endproperty
  property p_acq_hold; seq_state == ACS_ACQ |=> seq_state != ACS_IDLE; endproperty
  property p_excl; conv_active |-> !sample_en; endproperty
  property p_resume; $fell(conv_active) |-> ##[0:1] sample_en; endproperty
  property p_gap; bit_strobe |=> !bit_strobe; endproperty
  property p_strobe; bit_strobe |-> !sample_en; endproperty
  property p_busy; s_busy_rd |=> reg_rdata[0]; endproperty
  a_start: assert property (p_start) else $error("start not taken");
  a_acq_samp: assert property (p_acq_samp) else $error("no sampling");
  a_acq_hold: assert property (p_acq_hold) else $error("acq aborted");
  a_excl: assert property (p_excl) else $error("sample in conv");
  a_resume: assert property (p_resume) else $error("no resume");
  a_gap: assert property (p_gap) else $error("strobe too long");
  a_strobe: assert property (p_strobe) else $error("strobe out of conv");
  a_busy: assert property (p_busy) else $error("busy not shown");
endmodule
bind acs_seq acs_seq_chk acs_seq_chk_inst (.*);

// ===== dv/acs_seq_tb.sv
// Purpose: directed bench for acs_seq
// Assumes: inputs move on the edge through nonblocking assignments
// Notes: rc clock odd half-period keeps it unrelated to sys_clk
`timescale 1ns/1ps
`include "acs_cfg.svh"
module acs_seq_tb;
  import acs_pkg::*;
  logic sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, rc_clk_in = 0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic sample_en, conv_active, bit_strobe, irq;
  acs_state_t seq_state;
  int err_count = 0, compares = 0, cyc = 0, ns, na, gap, last, t, i, r;
  acs_seq acs_seq_inst (.*);
  always #2 sys_clk = ~sys_clk;
  always #37 rc_clk_in = ~rc_clk_in;
  always @(posedge sys_clk) begin
    cyc++;
    if (bit_strobe === 1'b1) begin
      ns++;
      gap = cyc - last;
      last = cyc;
    end
    if (seq_state === ACS_ACQ) na++;
  end
  task give_verdict;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // strobe dropped with an idle edge after it, so back-to-back calls never collide
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk) reg_wr <= 1'b0;
    @(posedge sys_clk) #1;
  endtask
  task rd(input logic [2:0] a, input logic [7:0] exp, input string nm);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk) reg_rd <= 1'b0;
    #1 chk(nm, reg_rdata, exp);
    @(posedge sys_clk) #1;
  endtask
  task conv(input logic [7:0] tm, input int p);
    wr(3'h1, tm);
    ns = 0;
    na = 0;
    wr(3'h0, 8'h01);
    wr(3'h0, 8'h01);
    rd(3'h0, 8'h01, "busy");
    for (t = 0; t < 2000 && seq_state !== ACS_IDLE; t++) #4;
    if (t >= 2000) begin
      chk("timeout", 1, 0);
      give_verdict();
    end
    #4 chk("bits", ns, 11);
    if (p > 0) chk("period", gap, p);
    if (p > 0) chk("acq", na, tm[5:3] * p);
    chk("resume", {sample_en, conv_active}, 2'b10);
    rd(3'h0, 8'h00, "go");
    $display("test timing %h done", tm);
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk) #1;
    rd(3'h1, 8'h00, "timing");
    rd(3'h7, 8'h00, "unmapped");
    $display("test reset values done");
    for (r = 0; r < 2; r++) begin
      for (i = 0; i < 6; i++) begin
        conv({2'b00, (i == 0) ? 3'h0 : 3'(i + 2), i[0], i[2:1]}, 2 << i);
      end
    end
    conv(8'h03, 0);
    rd(3'h2, 8'h01, "done");
    wr(3'h4, 8'h01);
    chk("irq", irq, 1'b1);
    wr(3'h4, 8'h00);
    chk("irq", irq, 1'b0);
    wr(3'h3, 8'h01);
    rd(3'h2, 8'h00, "done");
    $display("test irq done");
    give_verdict();
  end
endmodule
